// ==== flc_flash_model.sv ====
`timescale 1ns/1ps
module flc_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h5E, // Arbitrary value
  parameter int BUSY_NS = 800,
  parameter logic SUPPLY_OK = 1'b1
) (
  // Bus pins
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_reset_powerdown_n,
  input wire logic [20:0] i_addr,
  input wire logic [7:0] i_dq,
  // Device side
  output logic [7:0] o_dq,
  output logic o_drv,
  output logic o_ready_busy_n,
  output logic [15:0] o_codes
);
  logic [7:0] mem [logic [20:0]];
  logic [31:0] lock_q = '0;
  logic master_q = 1'b0;
  logic busy_q = 1'b0;
  logic [1:0] mode_q = 2'h0;
  logic [7:0] pend_q = 8'h00;
  logic [7:0] rdata;
  logic [15:0] codes_q = 16'h0000;
  event go;
  // Last two bytes written, newest in the low byte
  assign o_codes = codes_q;
  // Busy pin low only while running
  assign o_ready_busy_n = !busy_q || !i_reset_powerdown_n;
  assign o_drv = !i_ce_n && !i_oe_n && i_we_n && i_reset_powerdown_n;
  assign o_dq = o_drv ? rdata : ~rdata; // No pull-up, so released bus is inverted
  always @* begin
    case (mode_q)
      2'h0: rdata = mem.exists(i_addr) ? mem[i_addr] : i_addr[7:0] ^ 8'h5A;
      2'h1: rdata = (i_addr[1:0] == 2'h0) ? MAKER_CODE : (i_addr[1:0] == 2'h1) ? DEVICE_CODE :
                    {7'h00, (i_addr[1:0] == 2'h2) ? lock_q[i_addr[20:16]] : master_q};
      default: rdata = busy_q ? 8'h00 : 8'h80;
    endcase
  end
  // Capture on first rising write or select
  always @(posedge i_we_n or posedge i_ce_n) begin
    if (i_reset_powerdown_n && i_oe_n && (i_we_n != i_ce_n)) begin
      codes_q = {codes_q[7:0], i_dq};
      if (pend_q != 8'h00) begin
        mode_q = 2'h2;
        if (SUPPLY_OK && (pend_q == 8'h40 || pend_q == 8'h10) && !lock_q[i_addr[20:16]]) begin
          mem[i_addr] = i_dq;
          ->go;
        end
        if (SUPPLY_OK && pend_q == 8'h20 && i_dq == 8'hD0 && !lock_q[i_addr[20:16]]) begin
          mem[i_addr] = 8'hFF;
          ->go;
        end
        // Lock bits, no override level here
        if (SUPPLY_OK && pend_q == 8'h60 && !master_q) begin
          if (i_dq == 8'h01) lock_q[i_addr[20:16]] = 1'b1;
          if (i_dq == 8'hD0) lock_q = '0;
          ->go;
        end
      end else if (i_dq == 8'hFF) begin
        if (!busy_q) mode_q = 2'h0;
      end else if (i_dq == 8'h90) begin
        mode_q = 2'h1;
      end else if (i_dq != 8'h50) begin
        mode_q = 2'h2;
      end
      pend_q = (pend_q == 8'h00 && (i_dq == 8'h20 || i_dq == 8'h40 || i_dq == 8'h10 || i_dq == 8'h60)) ? i_dq : 8'h00;
    end
  end
  // Operation time of the state machine
  always @(go) begin
    busy_q = 1'b1;
    #(BUSY_NS);
    busy_q = 1'b0;
  end
  always @(negedge i_reset_powerdown_n) begin
    busy_q = 1'b0;
    mode_q = 2'h0;
    pend_q = 8'h00;
  end
endmodule

// ==== flc_host.sv ====
`timescale 1ns/1ps

// How it works
// - Read array command writes FFH
// - Suspend writes B0H, resume writes D0H
// - Identifier mode writes 90H, then reads
// - Identifier mode left by any other command except clear status
// - Status read mode writes 70H
// - Clear status writes 50H
// - Erase writes 20H then D0H, same block
// - Block lock writes 60H then 01H
// - Master lock writes 60H then F1H
// - Write: enable and select low, output high
module flc_host #(
  parameter int AW = 21
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // User command port
  input wire logic I_CMD_VALID,
  input wire flc_pkg::flc_op_t I_CMD_OP,
  input wire logic [AW-1:0] I_CMD_ADDR,
  input wire logic [7:0] I_CMD_DATA,
  output logic O_CMD_READY,
  output logic O_CMD_DONE,
  output logic O_CMD_REFUSED,
  output logic O_RD_VALID,
  output logic [7:0] O_RD_DATA,
  output flc_pkg::flc_mode_t O_MODE,
  output logic O_DEV_BUSY,
  // Flash pins
  output logic O_CE_N,
  output logic O_OE_N,
  output logic O_WE_N,
  output logic O_RESET_POWERDOWN_N,
  output logic [AW-1:0] O_ADDR,
  input wire logic [7:0] I_DQ,
  output logic [7:0] O_DQ,
  output logic O_DQ_OE,
  input wire logic I_READY_BUSY_N
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (AW < 2 || AW > 32) begin : g_bad_aw
    $error("flc_host: AW must be 2 to 32");
  end

  typedef enum {S_RST, S_WAKE, S_IDLE, S_WSET, S_WLOW, S_WREL, S_WOFF, S_RSET, S_RLOW, S_GAP} flc_state_t;

  flc_state_t state_q;
  flc_pkg::flc_pins_t pins_q;
  flc_pkg::flc_seq_t seq;
  flc_pkg::flc_op_t op_q;
  flc_pkg::flc_mode_t mode_q;
  logic [AW-1:0] addr_q;
  logic [flc_pkg::CNT_W-1:0] cnt_q;
  logic [7:0] c2_q;
  logic two_q;
  logic wr_q;
  logic ready_q;
  logic done_q;
  logic refused_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;
  logic busy_q;
  logic ryb_s1_q;
  logic ryb_s2_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic accept;
  logic gap_end;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  // Both stages always clocked; only stage two is read
  always_ff @(posedge I_CORE_CLK) begin
    ryb_s1_q <= I_READY_BUSY_N;
    ryb_s2_q <= ryb_s1_q;
    dq_s1_q <= I_DQ;
    dq_s2_q <= dq_s1_q;
  end

  // Busy flag for the user
  // busy follows pin
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= ~ryb_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Unknown op codes decode as not ok and are refused
  always_comb begin
    seq = '0;
    seq.ok = 1'b1;
    unique case (I_CMD_OP)
      flc_pkg::OP_READ: seq.c1 = 8'h00;
      flc_pkg::OP_RD_ARRAY: seq.c1 = flc_pkg::CMD_READ_ARRAY;
      flc_pkg::OP_RD_ID: seq.c1 = flc_pkg::CMD_READ_ID;
      flc_pkg::OP_RD_STATUS: seq.c1 = flc_pkg::CMD_READ_STATUS;
      flc_pkg::OP_CLR_STATUS: seq.c1 = flc_pkg::CMD_CLEAR_STATUS;
      flc_pkg::OP_ERASE: begin
        seq.two = 1'b1;
        seq.c1 = flc_pkg::CMD_ERASE_SETUP;
        seq.c2 = flc_pkg::CMD_CONFIRM;
      end
      flc_pkg::OP_PROGRAM: begin
        seq.two = 1'b1;
        seq.c1 = flc_pkg::CMD_PROGRAM_SETUP;
        seq.c2 = I_CMD_DATA;
      end
      flc_pkg::OP_SUSPEND: seq.c1 = flc_pkg::CMD_SUSPEND;
      flc_pkg::OP_RESUME: seq.c1 = flc_pkg::CMD_CONFIRM;
      flc_pkg::OP_LOCK_BLOCK: begin
        seq.two = 1'b1;
        seq.c1 = flc_pkg::CMD_LOCK_SETUP;
        seq.c2 = flc_pkg::CMD_LOCK_BLOCK;
      end
      flc_pkg::OP_LOCK_MASTER: begin
        seq.two = 1'b1;
        seq.c1 = flc_pkg::CMD_LOCK_SETUP;
        seq.c2 = flc_pkg::CMD_LOCK_MASTER;
      end
      flc_pkg::OP_UNLOCK_ALL: begin
        seq.two = 1'b1;
        seq.c1 = flc_pkg::CMD_LOCK_SETUP;
        seq.c2 = flc_pkg::CMD_CONFIRM;
      end
      default: seq.ok = 1'b0;
    endcase
  end

  assign accept = I_CMD_VALID && ready_q;
  assign gap_end = (state_q == S_GAP) && (cnt_q == '0) && !two_q;

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Write enable always moves alone; after a read, select and output enable rise in the same cycle
  always_ff @(posedge I_CORE_CLK) begin
    done_q <= 1'b0;
    refused_q <= 1'b0;
    rd_valid_q <= 1'b0;
    if (I_RST) begin
      state_q <= S_RST;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_powerdown_n: 1'b0, dq_oe: 1'b0, dq: 8'h00};
      cnt_q <= flc_pkg::PWRDN_LOW_CYC - 1'b1;
      addr_q <= '0;
      c2_q <= 8'h00;
      two_q <= 1'b0;
      wr_q <= 1'b0;
      op_q <= flc_pkg::OP_READ;
      ready_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      unique case (state_q)
        S_RST: begin
          if (cnt_q == '0) begin
            pins_q.reset_powerdown_n <= 1'b1;
            cnt_q <= flc_pkg::WAKE_CYC - 1'b1;
            state_q <= S_WAKE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_WAKE: begin
          if (cnt_q == '0) begin
            ready_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_IDLE: begin
          if (accept) begin
            if (!seq.ok || (I_CMD_OP == flc_pkg::OP_RD_ARRAY && !ryb_s2_q)) begin
              refused_q <= 1'b1;
            end else begin
              ready_q <= 1'b0;
              op_q <= I_CMD_OP;
              addr_q <= I_CMD_ADDR;
              c2_q <= seq.c2;
              two_q <= seq.two;
              wr_q <= (I_CMD_OP != flc_pkg::OP_READ);
              pins_q.ce_n <= 1'b0;
              if (I_CMD_OP == flc_pkg::OP_READ) begin
                state_q <= S_RSET;
              end else begin
                // drive only with output enable high
                pins_q.dq_oe <= 1'b1;
                pins_q.dq <= seq.c1;
                state_q <= S_WSET;
              end
            end
          end
        end
        // write strobe with output enable high
        S_WSET: begin
          pins_q.we_n <= 1'b0;
          cnt_q <= flc_pkg::WE_LOW_CYC - 1'b1;
          state_q <= S_WLOW;
        end
        S_WLOW: begin
          if (cnt_q == '0) begin
            pins_q.we_n <= 1'b1;
            state_q <= S_WREL;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_WREL: begin
          pins_q.ce_n <= 1'b1;
          state_q <= S_WOFF;
        end
        S_WOFF: begin
          pins_q.dq_oe <= 1'b0;
          cnt_q <= flc_pkg::RECOVER_CYC - 1'b1;
          state_q <= S_GAP;
        end
        S_RSET: begin
          pins_q.oe_n <= 1'b0;
          cnt_q <= flc_pkg::ACCESS_CYC - 1'b1;
          state_q <= S_RLOW;
        end
        S_RLOW: begin
          if (cnt_q == '0) begin
            rd_data_q <= dq_s2_q;
            rd_valid_q <= 1'b1;
            pins_q.oe_n <= 1'b1;
            pins_q.ce_n <= 1'b1;
            cnt_q <= flc_pkg::RECOVER_CYC - 1'b1;
            state_q <= S_GAP;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_GAP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (two_q) begin
            two_q <= 1'b0;
            pins_q.ce_n <= 1'b0;
            pins_q.dq_oe <= 1'b1;
            pins_q.dq <= c2_q;
            state_q <= S_WSET;
          end else begin
            done_q <= 1'b1;
            ready_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mode tracking
  // ----------------------------------------------------------------
  // Outside reset, mode changes only when a command write has completed
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || state_q == S_RST) begin
      mode_q <= flc_pkg::MODE_ARRAY;
    end else if (gap_end && wr_q) begin
      unique case (op_q)
        flc_pkg::OP_RD_ARRAY: mode_q <= flc_pkg::MODE_ARRAY;
        flc_pkg::OP_RD_ID: mode_q <= flc_pkg::MODE_ID;
        flc_pkg::OP_CLR_STATUS: mode_q <= mode_q;
        default: mode_q <= flc_pkg::MODE_STATUS;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_CMD_READY = ready_q;
  assign O_CMD_DONE = done_q;
  assign O_CMD_REFUSED = refused_q;
  assign O_RD_VALID = rd_valid_q;
  assign O_RD_DATA = rd_data_q;
  assign O_MODE = mode_q;
  assign O_DEV_BUSY = busy_q;
  assign O_CE_N = pins_q.ce_n;
  assign O_OE_N = pins_q.oe_n;
  assign O_WE_N = pins_q.we_n;
  assign O_RESET_POWERDOWN_N = pins_q.reset_powerdown_n;
  assign O_ADDR = addr_q;
  assign O_DQ = pins_q.dq;
  assign O_DQ_OE = pins_q.dq_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_no_bus_fight: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_DQ_OE |-> O_OE_N) else $error("data driven while output enable low");

  a_write_strobe: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !O_WE_N |-> (!O_CE_N && O_OE_N && O_DQ_OE)) else $error("bad write strobe");

  a_we_rises_first: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $rose(O_WE_N) |-> !O_CE_N ##1 O_CE_N) else $error("select rose before write enable");

  a_reset_pin_low: assert property (@(posedge I_CORE_CLK)
    I_RST |=> !O_RESET_POWERDOWN_N && !O_CMD_READY) else $error("reset pin not low in reset");

  a_array_refused: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (accept && I_CMD_OP == flc_pkg::OP_RD_ARRAY && !ryb_s2_q) |=> O_CMD_REFUSED && O_CMD_READY)
    else $error("array read issued while busy");

  a_erase_pair: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (accept && seq.ok && I_CMD_OP == flc_pkg::OP_ERASE) |=> O_DQ == flc_pkg::CMD_ERASE_SETUP
    ##[1:40] (O_DQ == flc_pkg::CMD_CONFIRM && !O_WE_N)) else $error("erase pair not written");

  a_read_returns: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    $fell(O_OE_N) |-> ##[1:20] O_RD_VALID) else $error("read data never returned");

  a_mode_status: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (gap_end && wr_q && op_q == flc_pkg::OP_RD_STATUS) |=> O_MODE == flc_pkg::MODE_STATUS)
    else $error("status mode not tracked");

  a_wake_array: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (state_q == S_WAKE) |-> O_MODE == flc_pkg::MODE_ARRAY) else $error("mode not array after wake");

endmodule

// ==== flc_pkg.sv ====
package flc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WE_LOW_NS = 50;
  localparam int T_ACCESS_NS = 100;
  localparam int T_RECOVER_NS = 40;
  localparam int T_PWRDN_LOW_NS = 100;
  localparam int T_WAKE_NS = 1000;
  localparam int SYNC_STAGES = 2;
  localparam int CNT_W = 8;

  // Least times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] WE_LOW_CYC = CNT_W'(min_cycles(T_WE_LOW_NS));
  localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'(min_cycles(T_ACCESS_NS) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(min_cycles(T_RECOVER_NS));
  localparam logic [CNT_W-1:0] PWRDN_LOW_CYC = CNT_W'(min_cycles(T_PWRDN_LOW_NS));
  localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'(min_cycles(T_WAKE_NS));

  // ----------------------------------------------------------------
  // Command codes written on the data bus
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;

  // Identifier offsets, for the user's own reads
  localparam logic [1:0] ID_OFS_MAKER = 2'h0;
  localparam logic [1:0] ID_OFS_DEVICE = 2'h1;
  localparam logic [1:0] ID_OFS_BLOCK_LOCK = 2'h2;
  localparam logic [1:0] ID_OFS_MASTER_LOCK = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ, OP_RD_ARRAY, OP_RD_ID, OP_RD_STATUS, OP_CLR_STATUS, OP_ERASE,
    OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_LOCK_BLOCK, OP_LOCK_MASTER, OP_UNLOCK_ALL
  } flc_op_t;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} flc_mode_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
    logic dq_oe;
    logic [7:0] dq;
  } flc_pins_t;

  typedef struct packed {
    logic ok;
    logic two;
    logic [7:0] c1;
    logic [7:0] c2;
  } flc_seq_t;

endpackage

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    flc_pkg::flc_op_t op;
    logic [20:0] a;
    logic [7:0] d;
    logic [15:0] c;
    flc_pkg::flc_mode_t m;
    logic [7:0] x;
  } flc_row_t;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'h5E; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  flc_pkg::flc_op_t cmd_op = flc_pkg::OP_READ;
  logic [20:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, cmd_done, cmd_refused, rd_valid, dev_busy;
  logic ce_n, oe_n, we_n, reset_powerdown_n, dq_oe, m_drv, ready_busy_n_n, got_ref;
  logic [7:0] rd_data, host_dq, m_dq, dq_bus, rd_byte;
  logic [20:0] addr;
  logic [15:0] codes;
  flc_pkg::flc_mode_t mode;
  int errors = 0;
  int total_checks = 0;
  flc_row_t rows [27];
  // Bus level from both drivers
  assign dq_bus = dq_oe ? host_dq : (m_drv ? m_dq : ~host_dq);
  flc_host u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CMD_VALID(cmd_valid), .I_CMD_OP(cmd_op),
    .I_CMD_ADDR(cmd_addr), .I_CMD_DATA(cmd_data), .O_CMD_READY(cmd_ready), .O_CMD_DONE(cmd_done),
    .O_CMD_REFUSED(cmd_refused), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_MODE(mode),
    .O_DEV_BUSY(dev_busy), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
    .O_RESET_POWERDOWN_N(reset_powerdown_n), .O_ADDR(addr),
    .I_DQ(dq_bus), .O_DQ(host_dq), .O_DQ_OE(dq_oe), .I_READY_BUSY_N(ready_busy_n_n));
  flc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_reset_powerdown_n(reset_powerdown_n), .i_addr(addr), .i_dq(dq_bus), .o_dq(m_dq),
    .o_drv(m_drv),
    .o_ready_busy_n(ready_busy_n_n), .o_codes(codes));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One request through the user port, bounded waits
  task automatic do_cmd(input flc_pkg::flc_op_t op, input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rd_byte = 'x;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
      if (rd_valid === 1'b1) rd_byte = rd_data;
    end
    got_ref = cmd_refused;
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (dev_busy !== 1'b0 && n < 200) begin
      n++;
      @(posedge clk);
    end
  endtask
  task automatic reset_dut();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("reset_powerdown_n", 16'h0000, {15'h0000, reset_powerdown_n});
    chk("ready", 16'h0000, {15'h0000, cmd_ready});
    rst = 1'b0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk("reset_powerdown_n", 16'h0001, {15'h0000, reset_powerdown_n});
  endtask
  // Host never drives while output enable is low
  always @(posedge clk) begin
    if (dq_oe === 1'b1 && oe_n === 1'b0) begin
      errors++;
      $display("MISMATCH bus_drive expected 0 seen 1");
    end
  end
  initial begin
    #800000;
    errors++;
    complete_run();
  end
  initial begin
    rows = '{
      '{flc_pkg::OP_READ, 21'h000123, 8'h00, 16'h0000, flc_pkg::MODE_ARRAY, 8'h79},
      '{flc_pkg::OP_RD_ID, 21'h000000, 8'h00, 16'h0090, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_READ, 21'h000000, 8'h00, 16'h0000, flc_pkg::MODE_ID, MAKER},
      '{flc_pkg::OP_READ, 21'h000001, 8'h00, 16'h0000, flc_pkg::MODE_ID, DEVICE},
      '{flc_pkg::OP_LOCK_BLOCK, 21'h010000, 8'h00, 16'h6001, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_PROGRAM, 21'h010010, 8'h00, 16'h4000, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RD_ID, 21'h000000, 8'h00, 16'h0090, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_READ, 21'h010002, 8'h00, 16'h0000, flc_pkg::MODE_ID, 8'h01},
      '{flc_pkg::OP_READ, 21'h000002, 8'h00, 16'h0000, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_LOCK_MASTER, 21'h000000, 8'h00, 16'h60F1, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_UNLOCK_ALL, 21'h000000, 8'h00, 16'h60D0, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RD_ID, 21'h000000, 8'h00, 16'h0090, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_READ, 21'h010002, 8'h00, 16'h0000, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_READ, 21'h000003, 8'h00, 16'h0000, flc_pkg::MODE_ID, 8'h00},
      '{flc_pkg::OP_RD_ARRAY, 21'h000000, 8'h00, 16'h00FF, flc_pkg::MODE_ARRAY, 8'h00},
      '{flc_pkg::OP_READ, 21'h010010, 8'h00, 16'h0000, flc_pkg::MODE_ARRAY, 8'h4A},
      '{flc_pkg::OP_PROGRAM, 21'h000200, 8'hA5, 16'h40A5, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RD_ARRAY, 21'h000000, 8'h00, 16'h00FF, flc_pkg::MODE_ARRAY, 8'h00},
      '{flc_pkg::OP_READ, 21'h000200, 8'h00, 16'h0000, flc_pkg::MODE_ARRAY, 8'hA5},
      '{flc_pkg::OP_ERASE, 21'h000200, 8'h00, 16'h20D0, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RD_ARRAY, 21'h000000, 8'h00, 16'h00FF, flc_pkg::MODE_ARRAY, 8'h00},
      '{flc_pkg::OP_READ, 21'h000200, 8'h00, 16'h0000, flc_pkg::MODE_ARRAY, 8'hFF},
      '{flc_pkg::OP_SUSPEND, 21'h000000, 8'h00, 16'h00B0, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RESUME, 21'h000000, 8'h00, 16'h00D0, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_RD_STATUS, 21'h000000, 8'h00, 16'h0070, flc_pkg::MODE_STATUS, 8'h00},
      '{flc_pkg::OP_READ, 21'h000000, 8'h00, 16'h0000, flc_pkg::MODE_STATUS, 8'h80},
      '{flc_pkg::OP_CLR_STATUS, 21'h000000, 8'h00, 16'h0050, flc_pkg::MODE_STATUS, 8'h00}};
    reset_dut();
    // Table rows: code on the wire, read data, mode
    foreach (rows[i]) begin
      idle_wait();
      do_cmd(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == flc_pkg::OP_READ) begin
        chk("rd_data", {8'h00, rows[i].x}, {8'h00, rd_byte});
      end else begin
        chk("codes", rows[i].c, (rows[i].c[15:8] != 8'h00) ? codes : {8'h00, codes[7:0]});
      end
      chk("mode", {14'h0000, rows[i].m}, {14'h0000, mode});
      chk("addr", {rows[i].a[20:16], rows[i].a[10:0]}, {addr[20:16], addr[10:0]});
    end
    // Array read while an erase runs is refused
    idle_wait();
    do_cmd(flc_pkg::OP_ERASE, 21'h000300, 8'h00);
    do_cmd(flc_pkg::OP_RD_ARRAY, 21'h000000, 8'h00);
    chk("refused", 16'h0001, {15'h0000, got_ref});
    chk("busy_pin", 16'h0000, {15'h0000, ready_busy_n_n});
    chk("dev_busy", 16'h0001, {15'h0000, dev_busy});
    idle_wait();
    chk("busy_pin", 16'h0001, {15'h0000, ready_busy_n_n});
    chk("dev_busy", 16'h0000, {15'h0000, dev_busy});
    // Reserved operation code
    do_cmd(flc_pkg::flc_op_t'(4'hC), 21'h000000, 8'h00);
    chk("refused", 16'h0001, {15'h0000, got_ref});
    // Reset in identifier mode returns to array reads
    do_cmd(flc_pkg::OP_RD_ID, 21'h000000, 8'h00);
    reset_dut();
    do_cmd(flc_pkg::OP_READ, 21'h000456, 8'h00);
    chk("rd_data", 16'h000C, {8'h00, rd_byte});
    chk("mode", 16'h0000, {14'h0000, mode});
    do_cmd(flc_pkg::OP_RD_STATUS, 21'h000000, 8'h00);
    do_cmd(flc_pkg::OP_READ, 21'h000000, 8'h00);
    chk("status", 16'h0080, {8'h00, rd_byte});
    complete_run();
  end
endmodule
